/* hw/hbc_pkg.sv */
// package for the hardware break condition comparator
package hbc_pkg;
  localparam int ADDR_W   = 32;
  localparam int DATA_W   = 32;
  localparam int ADDRESS_SPACE_IDENT_W   = 8;
  localparam int CNT_W    = 12;
  localparam logic [CNT_W-1:0] CNT_RESET = 12'h001;
  localparam logic [ADDRESS_SPACE_IDENT_W-1:0] ADDRESS_SPACE_IDENT_RESET = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE   = 12'h001;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 12'h000;
  localparam logic [ADDR_W-1:0] IO_BASE_RESET = 32'hFF000000;
  localparam logic [ADDR_W-1:0] IO_MASK_RESET = 32'hFF000000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h00000000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;
  // access size selection
  typedef enum logic [1:0] {HBC_SZ_BYTE, HBC_SZ_WORD, HBC_SZ_LONG} hbc_size_t;
  // data bus selection
  typedef enum logic [1:0] {HBC_BUS_MAIN, HBC_BUS_X, HBC_BUS_Y} hbc_dbus_t;
  // bus state qualifier
  typedef enum logic [1:0] {HBC_BS_ALL, HBC_BS_CPU, HBC_BS_DMA} hbc_bstate_t;
  // direction qualifier
  typedef enum logic [1:0] {HBC_RW_ANY, HBC_RW_READ, HBC_RW_WRITE} hbc_dir_t;
endpackage

/* hw/hbc_break_match.sv */
// hardware break condition comparator, three channels
`timescale 1ns/1ns
module hbc_break_match #(
  parameter bit HAS_MMU = 1'b1                        // identifier compare present
) (
  input  wire logic                       clk,                  // core clock
  input  wire logic                       rst_n,                // async reset, low
  // observed bus cycle
  input  wire logic                       cyc_valid,            // bus cycle this clock
  input  wire logic [hbc_pkg::ADDR_W-1:0] cyc_addr,             // cycle address
  input  wire logic [hbc_pkg::DATA_W-1:0] cyc_data,             // main data bus
  input  wire logic [hbc_pkg::DATA_W-1:0] cyc_xdata,            // X memory data bus
  input  wire logic                       cyc_xvalid,           // X bus cycle
  input  wire logic [hbc_pkg::DATA_W-1:0] cyc_ydata,            // Y memory data bus
  input  wire logic                       cyc_yvalid,           // Y bus cycle
  input  wire logic [1:0]                 cyc_size,             // 0 byte 1 word 2 long
  input  wire logic                       cyc_write,            // 1 write, 0 read
  input  wire logic                       cyc_dma,              // 1 DMA, 0 CPU
  input  wire logic [hbc_pkg::ADDRESS_SPACE_IDENT_W-1:0] address_space_ident,  // current identifier
  input  wire logic                       tlb_load_instruction, // instruction completed
  // internal I/O area window
  input  wire logic [hbc_pkg::ADDR_W-1:0] io_base,              // I/O area base
  input  wire logic [hbc_pkg::ADDR_W-1:0] io_mask,              // I/O area decode mask
  // channel 1 setup
  input  wire logic                       c1_addr_dc,           // address don't-care
  input  wire logic [hbc_pkg::ADDR_W-1:0] c1_addr,              // address value
  input  wire logic [hbc_pkg::ADDR_W-1:0] c1_addr_mask,         // 1 = bit ignored
  input  wire logic                       c1_data_dc,           // data don't-care
  input  wire logic [hbc_pkg::DATA_W-1:0] c1_data,              // data value
  input  wire logic                       c1_dmask_en,          // user data mask on
  input  wire logic [hbc_pkg::DATA_W-1:0] c1_data_mask,         // 1 = bit ignored
  input  wire logic [1:0]                 c1_size,              // size select
  input  wire logic [1:0]                 c1_dbus,              // data bus select
  input  wire logic                       c1_address_space_ident_dc,           // identifier don't-care
  input  wire logic [hbc_pkg::ADDRESS_SPACE_IDENT_W-1:0] c1_address_space_ident,              // identifier value
  input  wire logic [1:0]                 c1_bstate,            // bus state select
  input  wire logic [1:0]                 c1_dir,               // direction select
  input  wire logic                       c1_cnt_dc,            // count don't-care
  input  wire logic [hbc_pkg::CNT_W-1:0]  c1_count,             // satisfaction count
  input  wire logic                       c1_cnt_load,          // restart count, pulse
  // channel 2 setup
  input  wire logic                       c2_addr_dc,           // address don't-care
  input  wire logic [hbc_pkg::ADDR_W-1:0] c2_addr,              // address value
  input  wire logic [hbc_pkg::ADDR_W-1:0] c2_addr_mask,         // 1 = bit ignored
  input  wire logic                       c2_address_space_ident_dc,           // identifier don't-care
  input  wire logic [hbc_pkg::ADDRESS_SPACE_IDENT_W-1:0] c2_address_space_ident,              // identifier value
  input  wire logic [1:0]                 c2_bstate,            // bus state select
  input  wire logic [1:0]                 c2_dir,               // direction select
  // channel 3 setup
  input  wire logic                       c3_tlb_en,            // break on tlb load
  input  wire logic                       c3_io_en,             // break on I/O access
  input  wire logic                       c3_io_wr_only,        // I/O writes only
  // results
  output logic                            break_req,            // one-cycle pulse
  output logic [2:0]                      break_chan,           // channels hit, with pulse
  output logic [hbc_pkg::CNT_W-1:0]       c1_remaining          // matches still needed
);

  logic                       brk_q, brk_d;
  logic [2:0]                 chan_q, chan_d;
  logic [hbc_pkg::CNT_W-1:0]  cnt_q, cnt_d;
  logic                       dmatch, m1, m2, m3, hit1;
  logic [1:0]                 base_ok;              // channels 1 and 2 only: address, identifier, state, direction
  logic [hbc_pkg::DATA_W-1:0] dsel, dmask;
  logic                       dvalid;

  // bus state and direction qualifier shared by channels 1 and 2
  // bus state code 3 and direction code 3 match nothing
  function automatic logic cyc_qual(input logic [1:0] bs, input logic [1:0] dir,
                                    input logic dma, input logic wr);
    logic ok_bs;
    logic ok_dir;
    ok_bs  = (bs == hbc_pkg::HBC_BS_ALL) || (bs == hbc_pkg::HBC_BS_CPU && !dma) ||
             (bs == hbc_pkg::HBC_BS_DMA && dma);
    ok_dir = (dir == hbc_pkg::HBC_RW_ANY) || (dir == hbc_pkg::HBC_RW_READ && !wr) ||
             (dir == hbc_pkg::HBC_RW_WRITE && wr);
    return ok_bs && ok_dir;
  endfunction

  // masked address compare, mask bit one ignores that bit
  function automatic logic addr_ok(input logic dc, input logic [hbc_pkg::ADDR_W-1:0] a,
                                   input logic [hbc_pkg::ADDR_W-1:0] v,
                                   input logic [hbc_pkg::ADDR_W-1:0] m);
    return dc || (((a ^ v) & ~m) == hbc_pkg::ADDR_ZERO);
  endfunction

  // identifier compare; compiled away when no memory management unit
  function automatic logic address_space_ident_ok(input logic dc, input logic [hbc_pkg::ADDRESS_SPACE_IDENT_W-1:0] a,
                                   input logic [hbc_pkg::ADDRESS_SPACE_IDENT_W-1:0] v);
    return !HAS_MMU || dc || (a == v);
  endfunction

  // channels 1 and 2 share the address, identifier, state and direction compare;
  // one loop keeps the two copies identical
  // channel 3 has no identifier or state compare and decodes address and write its own way, so it stays outside the loop
  generate
    for (genvar g = 0; g < 2; g++) begin : g_chan
      logic                       a_dc;   // address don't-care
      logic [hbc_pkg::ADDR_W-1:0] a_val;  // address value
      logic [hbc_pkg::ADDR_W-1:0] a_msk;  // address mask
      logic                       s_dc;   // identifier don't-care
      logic [hbc_pkg::ADDRESS_SPACE_IDENT_W-1:0] s_val;  // identifier value
      logic [1:0]                 bs;     // bus state select
      logic [1:0]                 dir;    // direction select
      logic                       q_ok;   // state and direction pass
      logic                       a_ok;   // address passes
      logic                       s_ok;   // identifier passes
      // pick this channel's setup
      assign a_dc  = (g == 0) ? c1_addr_dc   : c2_addr_dc;
      assign a_val = (g == 0) ? c1_addr      : c2_addr;
      assign a_msk = (g == 0) ? c1_addr_mask : c2_addr_mask;
      assign s_dc  = (g == 0) ? c1_address_space_ident_dc   : c2_address_space_ident_dc;
      assign s_val = (g == 0) ? c1_address_space_ident      : c2_address_space_ident;
      assign bs    = (g == 0) ? c1_bstate    : c2_bstate;
      assign dir   = (g == 0) ? c1_dir       : c2_dir;
      // a qualifier set to don't-care passes
      assign q_ok       = cyc_qual(bs, dir, cyc_dma, cyc_write);
      assign a_ok       = addr_ok(a_dc, cyc_addr, a_val, a_msk);
      assign s_ok       = address_space_ident_ok(s_dc, address_space_ident, s_val);
      assign base_ok[g] = q_ok && a_ok && s_ok;
    end
  endgenerate

  // channel match terms
  // the selected data bus brings its own strobe, so an X or Y cycle can be
  // judged even when the main bus is idle
  always_comb begin
    dvalid = cyc_valid;
    dsel   = cyc_data;
    if (c1_dbus == hbc_pkg::HBC_BUS_X) begin
      dvalid = cyc_xvalid;
      dsel   = cyc_xdata;
    end else if (c1_dbus == hbc_pkg::HBC_BUS_Y) begin
      dvalid = cyc_yvalid;
      dsel   = cyc_ydata;
    end
    dmask  = c1_dmask_en ? c1_data_mask : hbc_pkg::DATA_ZERO;
    // size and value only for channel 1; the other channels never see data
    dmatch = c1_data_dc ||
             (dvalid && (cyc_size == c1_size) &&
              (((dsel ^ c1_data) & ~dmask) == hbc_pkg::DATA_ZERO));
    // with data compared, X/Y data cycles qualify channel 1 even without a main bus cycle
    m1 = (cyc_valid || (!c1_data_dc && dvalid)) &&
         dmatch && base_ok[0];
    m2 = cyc_valid &&
         base_ok[1];
    // channel 3 ignores data, identifier, state and count; only its I/O term decodes the address against io_base and io_mask
    m3 = (c3_tlb_en && tlb_load_instruction) ||
         (c3_io_en && cyc_valid && (!c3_io_wr_only || cyc_write) &&
          (((cyc_addr ^ io_base) & io_mask) == hbc_pkg::ADDR_ZERO));
  end

  // satisfaction counter; counts down so remaining matches are visible
  // a load pulse wins over a match in the same cycle: that match is dropped,
  // so software should load only while the channel is quiet
  // a programmed count of zero behaves like one, since the compare is <= one
  // the reload keeps a long count armed for the next run without software
  // hit1 is the final channel 1 result, after the count
  always_comb begin
    cnt_d = cnt_q;
    hit1  = 1'b0;
    if (c1_cnt_load) begin
      cnt_d = c1_count;
    end else if (m1) begin
      if (c1_cnt_dc) begin
        hit1 = 1'b1;
      end else if (cnt_q <= hbc_pkg::CNT_ONE) begin
        hit1  = 1'b1;
        cnt_d = c1_count; // rearm so the next run needs the full count again
      end else begin
        cnt_d = cnt_q - hbc_pkg::CNT_ONE;
      end
    end
  end

  // break pulse: registered, so it lags the matching cycle by one clock
  // back-to-back matches give back-to-back pulses; the debug side must not
  // expect a gap between two requests
  // flags of all channels that hit in the same cycle show together
  always_comb begin
    chan_d = {m3, m2, hit1};
    brk_d  = |chan_d;
  end

  // state registers
  // only the counter, the pulse and the channel flags are state; every
  // compare above is combinational on the observed cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= hbc_pkg::CNT_RESET;
      brk_q  <= 1'b0;
      chan_q <= 3'h0;
    end else begin
      cnt_q  <= cnt_d;
      brk_q  <= brk_d;
      chan_q <= chan_d;
    end
  end

  // outputs straight from the registers
  assign break_req    = brk_q;
  assign break_chan   = chan_q;
  assign c1_remaining = cnt_q;

endmodule

/* tb/hbc_break_match_checker.sv */
// port assertions for the break comparator
`timescale 1ns/1ns
module hbc_break_match_checker (
  input wire logic        clk,                  // core clock
  input wire logic        rst_n,                // reset, low
  input wire logic        cyc_valid,            // main strobe
  input wire logic        cyc_xvalid,           // X strobe
  input wire logic        cyc_yvalid,           // Y strobe
  input wire logic        tlb_load_instruction, // tlb load done
  input wire logic        c3_tlb_en,            // ch3 tlb on
  input wire logic        c1_cnt_dc,            // count off
  input wire logic        c1_cnt_load,          // count load
  input wire logic [11:0] c1_count,             // count value
  input wire logic        break_req,            // break pulse
  input wire logic [2:0]  break_chan,           // channels hit
  input wire logic [11:0] c1_remaining          // counter
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_REQ_CHAN: assert property (break_req == (break_chan != 3'h0)) else $error("pulse and flags differ");
  AST_CAUSE: assert property (break_req |-> $past(cyc_valid | cyc_xvalid | cyc_yvalid | tlb_load_instruction))
    else $error("break with no cycle");
  AST_TLB: assert property (tlb_load_instruction && c3_tlb_en |=> break_req && break_chan[2]) else $error("tlb");
  AST_QUIET: assert property (!(cyc_valid | cyc_xvalid | cyc_yvalid) && !(tlb_load_instruction && c3_tlb_en)
    |=> !break_req) else $error("break while quiet");
  AST_LOAD: assert property (c1_cnt_load && c1_count != 12'h000 |=> c1_remaining == $past(c1_count))
    else $error("count load");
  AST_LOAD_WINS: assert property (c1_cnt_load |=> !break_chan[0]) else $error("break on load");
  AST_DC_HOLD: assert property (c1_cnt_dc && !c1_cnt_load |=> $stable(c1_remaining)) else $error("count moved");
  AST_RELOAD: assert property (break_chan[0] && !$past(c1_cnt_dc) |-> c1_remaining == $past(c1_count))
    else $error("no reload");
endmodule

/* tb/hbc_bus_model.sv */
// bus cycle source standing in for the core and DMA
`timescale 1ns/1ns
module hbc_bus_model (
  input  wire logic   clk,                  // core clock
  output logic        cyc_valid,            // main strobe
  output logic        cyc_xvalid,           // X strobe
  output logic        cyc_yvalid,           // Y strobe
  output logic [31:0] cyc_addr,             // address
  output logic [31:0] cyc_data,             // main data
  output logic [31:0] cyc_xdata,            // X data
  output logic [31:0] cyc_ydata,            // Y data
  output logic [1:0]  cyc_size,             // size code
  output logic        cyc_write,            // write
  output logic        cyc_dma,              // DMA owner
  output logic        tlb_load_instruction  // tlb load done
);
  // quiet at time zero
  initial {cyc_valid, cyc_xvalid, cyc_yvalid, cyc_write, cyc_dma, tlb_load_instruction, cyc_size,
           cyc_addr, cyc_data, cyc_xdata, cyc_ydata} = '0;
  // kind k: 0 main, 1 X, 2 Y, 3 tlb load; launched just after an edge
  task automatic issue(int k, logic [31:0] a, d, logic [1:0] sz, logic wr, dma);
    @(posedge clk);
    {cyc_valid, cyc_xvalid, cyc_yvalid, tlb_load_instruction} <= {k == 0, k == 1, k == 2, k == 3};
    {cyc_addr, cyc_data, cyc_xdata, cyc_ydata} <= {a, d, d, d};
    {cyc_size, cyc_write, cyc_dma} <= {sz, wr, dma};
  endtask
  // released lines flip, so a stale value never passes for a live one
  task automatic idle;
    @(posedge clk);
    {cyc_valid, cyc_xvalid, cyc_yvalid, tlb_load_instruction} <= 4'h0;
    {cyc_addr, cyc_data, cyc_xdata, cyc_ydata} <= ~{cyc_addr, cyc_data, cyc_xdata, cyc_ydata};
  endtask
endmodule

/* tb/hbc_break_match_tb.sv */
// self-checking bench for the break comparator
`timescale 1ns/1ns
module hbc_break_match_tb;
  logic clk, rst_n, cyc_valid, cyc_xvalid, cyc_yvalid, cyc_write, cyc_dma, tlb_load_instruction, break_req;
  logic c1_addr_dc, c1_data_dc, c1_dmask_en, c1_address_space_ident_dc, c1_cnt_dc, c1_cnt_load, c2_addr_dc, c2_address_space_ident_dc;
  logic c3_tlb_en, c3_io_en, c3_io_wr_only, m;
  logic [31:0] cyc_addr, cyc_data, cyc_xdata, cyc_ydata, io_base, io_mask, c1_addr, c1_addr_mask;
  logic [31:0] c1_data, c1_data_mask, c2_addr, c2_addr_mask;
  logic [7:0] address_space_ident, c1_address_space_ident, c2_address_space_ident;
  logic [1:0] cyc_size, c1_size, c1_dbus, c1_bstate, c1_dir, c2_bstate, c2_dir;
  logic [11:0] c1_count, c1_remaining;
  logic [2:0] break_chan, nm_chan;
  logic nm_req;
  localparam logic [31:0] a1 = 32'h00001000;
  int err_total = 0;
  int checked = 0;
  int b, d;
  hbc_break_match dut (.*);
  // variant without memory management unit: identifier compare is absent
  hbc_break_match #(.HAS_MMU(1'b0)) dut_nommu (.*, .break_req(nm_req), .break_chan(nm_chan), .c1_remaining());
  hbc_bus_model bus (.*);
  task automatic cmp(string nm, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // one cycle then an idle one; the registered break shows after the idle edge
  task automatic hit(int k, logic [31:0] a, dv, logic [1:0] sz, logic wr, dma, logic [2:0] ch);
    bus.issue(k, a, dv, sz, wr, dma);
    bus.idle();
    #1;
    cmp("break_chan", ch, break_chan);
    cmp("break_req", ch != 3'h0, break_req);
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // setup changes land off the edge, a cycle ahead of the traffic they qualify
  initial begin
    rst_n = 1'b0;
    {c1_data_dc, c1_address_space_ident_dc, c1_cnt_dc} = 3'h7;
    {c1_addr_dc, c1_dmask_en, c1_cnt_load, c2_addr_dc, c2_address_space_ident_dc, c3_tlb_en, c3_io_en, c3_io_wr_only} = '0;
    {c1_size, c1_dbus, c1_bstate, c1_dir, c2_bstate, c2_dir, address_space_ident, c1_address_space_ident, c2_address_space_ident} = '0;
    {c1_addr_mask, c1_data_mask, c2_addr_mask, c1_data} = '0;
    {c1_addr, c2_addr, c1_count} = {a1, 32'h00002000, hbc_pkg::CNT_RESET};
    {io_base, io_mask} = {hbc_pkg::IO_BASE_RESET, hbc_pkg::IO_MASK_RESET};
    repeat (8) @(posedge clk);
    cmp("c1_remaining", 32'h1, c1_remaining);
    rst_n <= 1'b1;
    hit(0, a1, 32'h0, 2'h0, 1'b0, 1'b0, 3'h1);
    hit(0, 32'h00001004, 32'h0, 2'h0, 1'b0, 1'b0, 3'h0);
    hit(0, 32'h00002000, 32'h0, 2'h0, 1'b0, 1'b0, 3'h2);
    c1_data_dc <= 1'b0;
    c1_data <= 32'h000000A5;
    for (int i = 0; i < 3; i++) begin
      c1_size <= 2'(i);
      hit(0, a1, 32'h000000A5, 2'(i), 1'b0, 1'b0, 3'h1);
      hit(0, a1, 32'h000000A5, 2'((i + 1) % 3), 1'b0, 1'b0, 3'h0);
      hit(0, a1, 32'h000000A4, 2'(i), 1'b0, 1'b0, 3'h0);
    end
    {c1_dmask_en, c1_data_mask} <= {1'b1, 32'h00000001};
    hit(0, a1, 32'h000000A4, 2'h2, 1'b0, 1'b0, 3'h1);
    {c1_addr_dc, c1_dbus} <= 3'h5;
    hit(1, 32'h0, 32'h000000A5, 2'h2, 1'b0, 1'b0, 3'h1);
    c1_dbus <= 2'h2;
    hit(0, a1, 32'h000000A5, 2'h2, 1'b0, 1'b0, 3'h0);
    hit(2, 32'h0, 32'h000000A5, 2'h2, 1'b0, 1'b0, 3'h1);
    {c1_data_dc, c1_addr_dc, c1_address_space_ident_dc, c1_address_space_ident} <= {3'h4, 8'h05};
    hit(0, a1, 32'h0, 2'h0, 1'b0, 1'b0, 3'h0);
    cmp("nommu break_chan", 3'h1, nm_chan);
    cmp("nommu break_req", 1'b1, nm_req);
    {address_space_ident, c2_address_space_ident, c2_addr_dc} <= {8'h05, 8'h05, 1'b1};
    for (int i = 0; i < 36; i++) begin
      b = i / 12;
      d = i / 4 % 3;
      {c1_bstate, c1_dir, c2_bstate, c2_dir} <= {2'(b), 2'(d), 2'(b), 2'(d)};
      m = (b == 0 || b == (i[0] ? 2 : 1)) && (d == 0 || d == (i[1] ? 2 : 1));
      hit(0, a1, 32'h0, 2'h0, i[1], i[0], {1'b0, m, m});
    end
    {c1_bstate, c1_dir, c2_addr_dc, c1_cnt_dc, c1_count, c1_cnt_load} <= {6'h0, 12'hFFF, 1'b1};
    @(posedge clk);
    c1_cnt_load <= 1'b0;
    #1 cmp("c1_remaining", 32'hFFF, c1_remaining);
    repeat (4094) hit(0, a1, 32'h0, 2'h0, 1'b0, 1'b0, 3'h0);
    hit(0, a1, 32'h0, 2'h0, 1'b0, 1'b0, 3'h1);
    c1_cnt_dc <= 1'b1;
    hit(0, a1, 32'h0, 2'h0, 1'b0, 1'b0, 3'h1);
    cmp("c1_remaining", 32'hFFF, c1_remaining);
    c3_tlb_en <= 1'b1;
    hit(3, 32'h0, 32'h0, 2'h0, 1'b0, 1'b0, 3'h4);
    {c3_tlb_en, c3_io_en} <= 2'h1;
    hit(3, 32'h0, 32'h0, 2'h0, 1'b0, 1'b0, 3'h0);
    hit(0, 32'hFF000010, 32'h0, 2'h0, 1'b0, 1'b0, 3'h4);
    c3_io_wr_only <= 1'b1;
    hit(0, 32'hFF000010, 32'h0, 2'h0, 1'b0, 1'b0, 3'h0);
    hit(0, 32'hFF000010, 32'h0, 2'h0, 1'b1, 1'b0, 3'h4);
    test_done();
  end
endmodule
bind hbc_break_match hbc_break_match_checker chk (.clk, .rst_n, .cyc_valid, .cyc_xvalid, .cyc_yvalid,
  .tlb_load_instruction, .c3_tlb_en, .c1_cnt_dc, .c1_cnt_load, .c1_count, .break_req, .break_chan, .c1_remaining);
